// ---- design/phy_ctrl_pkg.sv ----
// Constants, register map and shared functions of the port control block
package phy_ctrl_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [7:0] PCS_IDX = 8'h19;
   localparam logic [7:0] IRQ_STATUS_IDX = 8'h1C;
   localparam logic [7:0] IRQ_MASK_IDX = 8'h1D;
   localparam int BYTE_SHIFT = 2;

   // Field positions of port_control_status
   localparam int AUTO_XOVER_BIT = 15;
   localparam int FORCE_XOVER_BIT = 14;
   localparam int PAUSE_RX_BIT = 13;
   localparam int PAUSE_TX_BIT = 12;
   localparam int FORCE_ERR_BIT = 11;
   localparam int LONG_SEQ_BIT = 10;
   localparam int RESULT_BIT = 9;
   localparam int RUN_BIT = 8;
   localparam int LED_BYPASS_BIT = 7;

   // Interrupt status and mask layout
   localparam int IRQ_W = 2;
   localparam int IRQ_FAIL_BIT = 0;
   localparam int IRQ_PAUSE_BIT = 1;

   // Advertised pause field: bit 1 asymmetric direction, bit 0 symmetric pause
   localparam int ADV_ASYM_BIT = 1;
   localparam int ADV_PAUSE_BIT = 0;

   // Values after reset
   localparam logic RST_CTRL_BIT = 1'h0;
   localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
   localparam logic [14:0] PRBS_SEED = 15'h7FFF;

   // Cycles filled before comparing: 15 history bits plus up to 16 cycles of loop latency
   localparam logic [4:0] SYNC_FILL = 5'h1F;

   // Next bit of the 9-stage or 15-stage sequence; h[0] is the newest bit
   function automatic logic prbs_next(input logic [14:0] h, input logic long_seq);
      prbs_next = long_seq ? (h[14] ^ h[13]) : (h[8] ^ h[4]);
   endfunction : prbs_next

   // Pause resolution; index 0 receive, index 1 transmit
   function automatic logic [1:0] pause_resolve(input logic [1:0] loc, input logic [1:0] lp);
      logic both;
      logic rx_only;
      logic tx_only;
      both = loc[ADV_PAUSE_BIT] & lp[ADV_PAUSE_BIT];
      rx_only = loc[ADV_PAUSE_BIT] & loc[ADV_ASYM_BIT] & ~lp[ADV_PAUSE_BIT] & lp[ADV_ASYM_BIT];
      tx_only = ~loc[ADV_PAUSE_BIT] & loc[ADV_ASYM_BIT] & lp[ADV_PAUSE_BIT] & lp[ADV_ASYM_BIT];
      pause_resolve = {both | tx_only, both | rx_only};
   endfunction : pause_resolve
endpackage : phy_ctrl_pkg

// ---- design/prbs_gen.sv ----
// Self-test pattern generator with single-bit error injection
`timescale 1ns/1ps
module prbs_gen
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic long_i,
   input wire logic inject_i,
   output logic bit_o
);
   typedef struct packed {
      logic [14:0] lfsr;
      logic out;
   } gen_state_t;

   gen_state_t state_ff;
   gen_state_t nxt_state;

   always_comb
   begin
      logic fb;
      fb = phy_ctrl_pkg::prbs_next(state_ff.lfsr, long_i);
      nxt_state = state_ff;
      if (!run_i)
      begin
         nxt_state.lfsr = phy_ctrl_pkg::PRBS_SEED;
         nxt_state.out = 1'h0;
      end
      else
      begin
         // Error goes on the line only, so the sequence itself stays intact
         nxt_state.lfsr = {state_ff.lfsr[13:0], fb};
         nxt_state.out = fb ^ inject_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff.lfsr <= phy_ctrl_pkg::PRBS_SEED;
         state_ff.out <= 1'h0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign bit_o = state_ff.out;
endmodule : prbs_gen

// ---- design/phy_control_register.sv ----
// Port control and status register with crossover, pause status and self-test
//
// Behaviour
// - Register sits at index 19h of the port's management space, 16 bits wide.
// - Bit 15 enables automatic crossover; its value after reset comes from a strap.
// - Bit 14 forces crossed pairs; reset value 0.
// - Bit 13 read-only: MAC should honour received pause frames.
// - Bit 12 read-only: MAC may send pause frames.
// - Pause bits follow the standard resolution table, only for full-duplex results.
// - Writing 1 to bit 11 injects one self-test error, then clears itself.
// - Bit 8 runs self-test; bit 9 reads pass, fail latched until stopped.
// - Bit 7 bypasses LED stretching so LEDs follow their raw sources.
`timescale 1ns/1ps
module phy_control_register
#(
   parameter int ADDR_W = 8,
   parameter int LED_W = 3
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic auto_crossover_strap_i,
   input wire logic auto_swap_i,
   input wire logic [1:0] local_ability_advert_i,
   input wire logic [1:0] partner_ability_i,
   input wire logic hcd_full_duplex_i,
   input wire logic selftest_rx_i,
   output logic selftest_tx_o,
   input wire logic [LED_W-1:0] led_raw_i,
   input wire logic [LED_W-1:0] led_stretched_i,
   output logic [LED_W-1:0] led_o,
   output logic auto_crossover_enable_o,
   output logic crossover_o,
   output logic irq_o
);
   if (ADDR_W < 8 || ADDR_W > 32 || LED_W < 1)
   begin : g_param_check
      $error("phy_control_register: unsupported parameter values");
   end

   typedef struct packed {
      logic strap_s1;
      logic strap_s2;
      logic rx_s1;
      logic rx_s2;
      logic loaded;
      logic auto_en;
      logic force_x;
      logic force_err;
      logic long_sel;
      logic run;
      logic led_bypass;
      logic fail;
      logic pause_rx;
      logic pause_tx;
      logic [14:0] rx_hist;
      logic [4:0] sync_cnt;
      logic [1:0] irq_st;
      logic [1:0] irq_mask;
      logic [31:0] rdata;
      logic crossover;
      logic [LED_W-1:0] led;
   } ctrl_state_t;

   ctrl_state_t state_ff;
   ctrl_state_t nxt_state;

   logic [ADDR_W-1:0] pcs_addr;
   logic [ADDR_W-1:0] ist_addr;
   logic [ADDR_W-1:0] imask_addr;
   logic hit_pcs;
   logic hit_ist;
   logic hit_imask;
   logic hit_any;
   logic wr_stb;
   logic [15:0] pcs_word;
   logic result;
   logic [1:0] pause_res;
   logic gen_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode and read word

   assign pcs_addr = ADDR_W'(phy_ctrl_pkg::PCS_IDX) << phy_ctrl_pkg::BYTE_SHIFT;
   assign ist_addr = ADDR_W'(phy_ctrl_pkg::IRQ_STATUS_IDX) << phy_ctrl_pkg::BYTE_SHIFT;
   assign imask_addr = ADDR_W'(phy_ctrl_pkg::IRQ_MASK_IDX) << phy_ctrl_pkg::BYTE_SHIFT;
   assign hit_pcs = (paddr_i == pcs_addr);
   assign hit_ist = (paddr_i == ist_addr);
   assign hit_imask = (paddr_i == imask_addr);
   assign hit_any = hit_pcs | hit_ist | hit_imask;
   // Zero wait states: read data is captured in the setup cycle
   assign pready_o = 1'h1;
   assign pslverr_o = psel_i & penable_i & ~hit_any;
   assign wr_stb = psel_i & penable_i & pwrite_i & hit_any;

   // Pass shows only while running and no mismatch has been seen
   assign result = state_ff.run & ~state_ff.fail;
   assign pause_res = phy_ctrl_pkg::pause_resolve(local_ability_advert_i, partner_ability_i);

   always_comb
   begin
      pcs_word = 16'h0000;
      pcs_word[phy_ctrl_pkg::AUTO_XOVER_BIT] = state_ff.auto_en;
      pcs_word[phy_ctrl_pkg::FORCE_XOVER_BIT] = state_ff.force_x;
      pcs_word[phy_ctrl_pkg::PAUSE_RX_BIT] = state_ff.pause_rx;
      pcs_word[phy_ctrl_pkg::PAUSE_TX_BIT] = state_ff.pause_tx;
      pcs_word[phy_ctrl_pkg::FORCE_ERR_BIT] = state_ff.force_err;
      pcs_word[phy_ctrl_pkg::LONG_SEQ_BIT] = state_ff.long_sel;
      pcs_word[phy_ctrl_pkg::RESULT_BIT] = result;
      pcs_word[phy_ctrl_pkg::RUN_BIT] = state_ff.run;
      pcs_word[phy_ctrl_pkg::LED_BYPASS_BIT] = state_ff.led_bypass;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      logic mismatch;
      logic [1:0] ev;
      mismatch = 1'h0;
      ev = 2'h0;
      nxt_state = state_ff;

      // Pin synchronisers
      nxt_state.strap_s1 = auto_crossover_strap_i;
      nxt_state.strap_s2 = state_ff.strap_s1;
      nxt_state.rx_s1 = selftest_rx_i;
      nxt_state.rx_s2 = state_ff.rx_s1;

      // Strap is caught once, on the first cycle after reset release
      if (!state_ff.loaded)
      begin
         nxt_state.loaded = 1'h1;
         nxt_state.auto_en = state_ff.strap_s2;
      end

      // Self-clears after one cycle; injection only lands if self-test runs
      nxt_state.force_err = 1'h0;

      if (psel_i && !penable_i)
      begin
         nxt_state.rdata = 32'h0000_0000;
         if (hit_pcs)
            nxt_state.rdata[15:0] = pcs_word;
         else if (hit_ist)
            nxt_state.rdata[phy_ctrl_pkg::IRQ_W-1:0] = state_ff.irq_st;
         else if (hit_imask)
            nxt_state.rdata[phy_ctrl_pkg::IRQ_W-1:0] = state_ff.irq_mask;
      end

      // Only writable fields are taken; status bits ignore write data
      if (wr_stb && hit_pcs)
      begin
         nxt_state.auto_en = pwdata_i[phy_ctrl_pkg::AUTO_XOVER_BIT];
         nxt_state.force_x = pwdata_i[phy_ctrl_pkg::FORCE_XOVER_BIT];
         nxt_state.force_err = pwdata_i[phy_ctrl_pkg::FORCE_ERR_BIT];
         nxt_state.long_sel = pwdata_i[phy_ctrl_pkg::LONG_SEQ_BIT];
         nxt_state.run = pwdata_i[phy_ctrl_pkg::RUN_BIT];
         nxt_state.led_bypass = pwdata_i[phy_ctrl_pkg::LED_BYPASS_BIT];
      end
      if (wr_stb && hit_imask)
         nxt_state.irq_mask = pwdata_i[phy_ctrl_pkg::IRQ_W-1:0];

      // Pause status only for a full-duplex result
      nxt_state.pause_rx = hcd_full_duplex_i & pause_res[0];
      nxt_state.pause_tx = hcd_full_duplex_i & pause_res[1];
      if (nxt_state.pause_rx != state_ff.pause_rx || nxt_state.pause_tx != state_ff.pause_tx)
         ev[phy_ctrl_pkg::IRQ_PAUSE_BIT] = 1'h1;

      // Stale idle bits must leave the history first; loops over 16 cycles read as fail on the 15-stage sequence
      if (!state_ff.run)
      begin
         nxt_state.fail = 1'h0;
         nxt_state.sync_cnt = 5'h00;
         nxt_state.rx_hist = 15'h0000;
      end
      else
      begin
         nxt_state.rx_hist = {state_ff.rx_hist[13:0], state_ff.rx_s2};
         if (state_ff.sync_cnt != phy_ctrl_pkg::SYNC_FILL)
            nxt_state.sync_cnt = state_ff.sync_cnt + 5'h01;
         else
            mismatch = state_ff.rx_s2 !=
               phy_ctrl_pkg::prbs_next(state_ff.rx_hist, state_ff.long_sel);
         if (mismatch)
         begin
            nxt_state.fail = 1'h1;
            ev[phy_ctrl_pkg::IRQ_FAIL_BIT] = ~state_ff.fail;
         end
      end

      // Write-one-to-clear; a new event in the same cycle wins
      if (wr_stb && hit_ist)
         nxt_state.irq_st = state_ff.irq_st & ~pwdata_i[phy_ctrl_pkg::IRQ_W-1:0];
      nxt_state.irq_st = nxt_state.irq_st | ev;

      nxt_state.crossover = state_ff.force_x | (state_ff.auto_en & auto_swap_i);
      nxt_state.led = state_ff.led_bypass ? led_raw_i : led_stretched_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= '0;
         // Strap synchroniser keeps running so the strap is settled when reset ends
         state_ff.strap_s1 <= nxt_state.strap_s1;
         state_ff.strap_s2 <= nxt_state.strap_s2;
         state_ff.auto_en <= phy_ctrl_pkg::RST_CTRL_BIT;
         state_ff.irq_st <= phy_ctrl_pkg::RST_IRQ;
         state_ff.irq_mask <= phy_ctrl_pkg::RST_IRQ;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pattern generator

   prbs_gen u_gen
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(state_ff.run),
      .long_i(state_ff.long_sel),
      .inject_i(state_ff.force_err),
      .bit_o(gen_bit)
   );

   assign selftest_tx_o = gen_bit;
   assign prdata_o = state_ff.rdata;
   assign led_o = state_ff.led;
   assign auto_crossover_enable_o = state_ff.auto_en;
   assign crossover_o = state_ff.crossover;
   assign irq_o = |(state_ff.irq_st & state_ff.irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic wr_pcs;
   assign wr_pcs = wr_stb & hit_pcs;

   chk_force_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_pcs |=> state_ff.force_x == $past(pwdata_i[phy_ctrl_pkg::FORCE_XOVER_BIT]))
      else $error("force crossover bit did not take written value");

   chk_force_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      state_ff.force_err |=> !state_ff.force_err || $past(wr_pcs))
      else $error("force error bit did not self-clear");

   chk_pause_half: assert property (@(posedge clk_i) disable iff (rst_i)
      !hcd_full_duplex_i |=> !state_ff.pause_rx && !state_ff.pause_tx)
      else $error("pause status set for half duplex");

   chk_pause_rx_both: assert property (@(posedge clk_i) disable iff (rst_i)
      hcd_full_duplex_i && local_ability_advert_i[0] && partner_ability_i[0]
      |=> state_ff.pause_rx)
      else $error("pause receive not resolved for symmetric pause");

   chk_pause_tx_asym: assert property (@(posedge clk_i) disable iff (rst_i)
      hcd_full_duplex_i && local_ability_advert_i == 2'h3 && partner_ability_i == 2'h2
      |=> !state_ff.pause_tx && state_ff.pause_rx)
      else $error("asymmetric pause resolved wrongly");

   chk_result_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      !state_ff.run |-> !result ##1 (state_ff.run || !state_ff.fail))
      else $error("self-test fail not cleared on stop");

   chk_fail_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      state_ff.fail && state_ff.run && !wr_pcs |=> state_ff.fail)
      else $error("self-test fail not latched");

   chk_ro_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_pcs && !state_ff.run && pwdata_i[phy_ctrl_pkg::RESULT_BIT]
      && !pwdata_i[phy_ctrl_pkg::RUN_BIT] |=> !result)
      else $error("write changed self-test result");

   chk_strap_load: assert property (@(posedge clk_i)
      $fell(rst_i) |-> state_ff.auto_en == 1'h0 ##1 state_ff.auto_en == $past(state_ff.strap_s2))
      else $error("strap not loaded after reset");

   chk_led_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
      state_ff.led_bypass && $stable(state_ff.led_bypass) |=> led_o == $past(led_raw_i))
      else $error("LED bypass not followed");

   chk_fail_event: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(state_ff.fail) |-> state_ff.irq_st[phy_ctrl_pkg::IRQ_FAIL_BIT])
      else $error("self-test fail did not set its status bit");

   cov_selftest_fail: cover property (@(posedge clk_i) disable iff (rst_i)
      state_ff.run ##[1:300] state_ff.fail);
   cov_force_err: cover property (@(posedge clk_i) disable iff (rst_i)
      state_ff.force_err && state_ff.run);
   cov_pause_both: cover property (@(posedge clk_i) disable iff (rst_i)
      state_ff.pause_rx && state_ff.pause_tx);
endmodule : phy_control_register

// ---- test/phy_control_register_tb_top.sv ----
// Self-checking testbench of the port control and status register
`timescale 1ns/1ps
module phy_control_register_tb_top;
   localparam logic [7:0] PCS_A = phy_ctrl_pkg::PCS_IDX << phy_ctrl_pkg::BYTE_SHIFT;
   localparam logic [7:0] STS_A = phy_ctrl_pkg::IRQ_STATUS_IDX << phy_ctrl_pkg::BYTE_SHIFT;
   localparam logic [7:0] MSK_A = phy_ctrl_pkg::IRQ_MASK_IDX << phy_ctrl_pkg::BYTE_SHIFT;
   // Sized for about 680 busy cycles, with margin
   localparam int LIMIT = 5000;
   logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic auto_crossover_strap_i, auto_swap_i, hcd_full_duplex_i;
   logic [1:0] local_ability_advert_i, partner_ability_i;
   logic selftest_rx_i, selftest_tx_o, auto_crossover_enable_o, crossover_o, irq_o;
   logic [2:0] led_raw_i, led_stretched_i, led_o;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   phy_control_register i_phy_control_register (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .auto_crossover_strap_i(auto_crossover_strap_i), .auto_swap_i(auto_swap_i),
      .local_ability_advert_i(local_ability_advert_i), .partner_ability_i(partner_ability_i),
      .hcd_full_duplex_i(hcd_full_duplex_i), .selftest_rx_i(selftest_rx_i),
      .selftest_tx_o(selftest_tx_o), .led_raw_i(led_raw_i), .led_stretched_i(led_stretched_i),
      .led_o(led_o), .auto_crossover_enable_o(auto_crossover_enable_o),
      .crossover_o(crossover_o), .irq_o(irq_o));
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // External loopback of the self-test pattern
   always @(posedge clk_i) selftest_rx_i <= selftest_tx_o;
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         num_errors++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (num_errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
      compares++;
      if (seen !== want)
      begin
         num_errors++;
         $display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, want);
      end
   endtask : chk
   // One APB transfer; entry waits an edge so psel is never driven twice in a time step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do
         @(posedge clk_i);
      while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] want, input string what);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, want, what);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      rd(PCS_A, 32'h0000_8000, "pcs after reset");
      rd(STS_A, 32'h0000_0000, "status after reset");
      rd(MSK_A, 32'h0000_0000, "mask after reset");
      chk(32'(auto_crossover_enable_o), 32'h1, "strap enable");
   endtask : test_reset
   task automatic test_rw();
      logic [31:0] r;
      logic e;
      wr(PCS_A, 32'h0000_F680);
      rd(PCS_A, 32'h0000_C480, "read-only bits kept");
      repeat (3) @(posedge clk_i);
      chk(32'(crossover_o), 32'h1, "forced crossover");
      chk(32'(led_o), 32'h5, "led bypass");
      wr(PCS_A, 32'h0000_8000);
      auto_swap_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(32'(crossover_o), 32'h1, "auto crossover");
      chk(32'(led_o), 32'h2, "led stretched");
      wr(PCS_A, 32'h0000_0000);
      repeat (3) @(posedge clk_i);
      chk(32'(crossover_o), 32'h0, "auto off");
      chk(32'(auto_crossover_enable_o), 32'h0, "enable off");
      apb(1'b1, 8'h60, 32'h0000_FFFF, r, e);
      chk(32'(e), 32'h1, "unmapped write error");
      apb(1'b0, 8'h60, 32'h0000_0000, r, e);
      chk({r[30:0], e}, 32'h1, "unmapped read");
      rd(PCS_A, 32'h0000_0000, "no alias write");
   endtask : test_rw
   task automatic test_pause();
      logic rx, tx;
      for (int i = 0; i < 32; i++)
      begin
         local_ability_advert_i <= 2'(i);
         partner_ability_i <= 2'(i >> 2);
         hcd_full_duplex_i <= i[4];
         rx = (i[0] & i[2]) | (i[0] & i[1] & ~i[2] & i[3]);
         tx = (i[0] & i[2]) | (~i[0] & i[1] & i[2] & i[3]);
         repeat (3) @(posedge clk_i);
         rd(PCS_A, {18'h0, rx & i[4], tx & i[4], 12'h000}, "pause");
      end
      local_ability_advert_i <= 2'h0;
      repeat (3) @(posedge clk_i);
      rd(STS_A, 32'h0000_0002, "pause event");
      chk(32'(irq_o), 32'h0, "masked irq");
      wr(MSK_A, 32'h0000_0002);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h1, "pause irq");
      wr(STS_A, 32'h0000_0003);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h0, "irq cleared");
      rd(STS_A, 32'h0000_0000, "status cleared");
   endtask : test_pause
   // Checks the pattern recurrence independently of the generator
   task automatic seq_check(input logic lng);
      logic [14:0] h;
      int bad;
      logic nb;
      h = 15'h0000;
      bad = 0;
      repeat (5) @(posedge clk_i);
      for (int n = 0; n < 60; n++)
      begin
         @(posedge clk_i);
         nb = lng ? (h[14] ^ h[13]) : (h[8] ^ h[4]);
         if (n >= 15 && nb !== selftest_tx_o)
            bad++;
         h = {h[13:0], selftest_tx_o};
      end
      chk(32'(bad), 32'h0, "pattern");
   endtask : seq_check
   task automatic test_selftest(input logic lng);
      logic [31:0] b;
      b = {21'h0, lng, 10'h000};
      wr(PCS_A, b);
      wr(PCS_A, b | 32'h0100);
      seq_check(lng);
      rd(PCS_A, b | 32'h0300, "self-test pass");
      wr(PCS_A, b | 32'h0900);
      repeat (40) @(posedge clk_i);
      rd(PCS_A, b | 32'h0100, "error latched, bit cleared");
      rd(STS_A, 32'h0000_0001, "fail event");
      wr(MSK_A, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h1, "fail irq");
      wr(STS_A, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h0, "fail irq cleared");
      wr(PCS_A, b);
      rd(PCS_A, b, "stopped");
      wr(PCS_A, b | 32'h0100);
      repeat (60) @(posedge clk_i);
      rd(PCS_A, b | 32'h0300, "fail cleared by stop");
      wr(PCS_A, b);
   endtask : test_selftest
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0000_0000;
      auto_crossover_strap_i = 1'b1;
      auto_swap_i = 1'b0;
      local_ability_advert_i = 2'h0;
      partner_ability_i = 2'h0;
      hcd_full_duplex_i = 1'b0;
      led_raw_i = 3'h5;
      led_stretched_i = 3'h2;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      test_reset();
      test_rw();
      test_pause();
      test_selftest(1'b0);
      test_selftest(1'b1);
      end_sim();
   end
endmodule : phy_control_register_tb_top
